// *** design/vector_regs.svh ***
// Constants for the reset and interrupt vectoring unit
`ifndef VECTOR_REGS_SVH
`define VECTOR_REGS_SVH

// ==========================================================
// Vector addresses
`define VEC_RESET        4'h0
`define VEC_EXT_IRQ_ZERO 4'h1
`define VEC_EXT_IRQ_ONE  4'h2
`define VEC_T1_CAPT      4'h3
`define VEC_T1_COMPA     4'h4
`define VEC_T1_COMPB     4'h5
`define VEC_T1_OVF       4'h6
`define VEC_T0_OVF       4'h7
`define VEC_SPI_STC      4'h8
`define VEC_UART_RXC     4'h9
`define VEC_UART_UDRE    4'hA
`define VEC_UART_TXC     4'hB
`define VEC_ANA_COMP     4'hC

// ==========================================================
// Source count and timing
`define NUM_SOURCES      12
`define RST_FILTER_NS    50
`define CLK_PERIOD_NS    100
`define RST_FILTER_CYC   (((`RST_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define FAST_START_CYC   256
`define SLOW_START_CYC   16384

`endif

// *** design/vector_pkg.sv ***
// Types for the reset and interrupt vectoring unit
package vector_pkg;

  // Reset sequencer states
  typedef enum logic [2:0] {
    ST_HOLD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } rst_state_t;

  // Interrupt request to the core
  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
  } vec_req_t;

endpackage

// *** design/sync_two_ff.sv ***
// Two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module sync_two_ff #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // ==========================================================
  // Synchroniser chain
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** design/irq_arbiter.sv ***
// Fixed-priority arbiter picking the lowest vector among requests
`timescale 1ns/1ps
`include "vector_regs.svh"
module irq_arbiter
  import vector_pkg::*;
#(
  parameter int N = `NUM_SOURCES
) (
  input  wire logic [N-1:0] pending,
  input  wire logic [N-1:0] enable,
  input  wire logic         global_en,
  output logic [N-1:0]      grant,
  output vec_req_t          req
);

  // Lowest set bit wins; vector address is its index plus one
  always_comb
  begin
    logic [N-1:0] live;
    live      = pending & enable & {N{global_en}};
    grant     = '0;
    req.valid = 1'b0;
    req.addr  = `VEC_RESET;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (live[i])
      begin
        grant     = '0;
        grant[i]  = 1'b1;
        req.valid = 1'b1;
        req.addr  = 4'((i + 1));
      end
    end
  end

endmodule

// *** design/reset_and_interrupt_vectoring.sv ***
// Reset combining, start-up delay and interrupt vectoring top
`timescale 1ns/1ps
`include "vector_regs.svh"
//
// Contract
// R1: Twelve sources, each its own vector
// R2: Taken only with source and global enable
// R3: Lowest vector address wins, reset first
// R4: All reset causes vector to zero
// R5: External irq zero 0x001, one 0x002
// R6: Timer vectors 0x003 through 0x007
// R7: Serial, uart, comparator 0x008 to 0x00C
// R8: Combine power-on, pin and watchdog resets
// R9: Pin low over 50 ns resets
// R10: Watchdog reset only when enabled, expired
// R11: Reset forces registers, fetch from zero
// R12: Delay 256 or 16K oscillator cycles
// R13: Delay timer clocked by watchdog oscillator
// R14: Pin held low extends power-on reset
// R15: Watchdog pulse; delay starts at its end
// R16: Accept clears global enable; return sets
// R17: Vectoring clears the served pending flag
// R18: Disabled requests stay pending until served
// R19: Address is vector number minus one
// R20: Delay counter cleared by any reset
module reset_and_interrupt_vectoring
  import vector_pkg::*;
#(
  parameter int N          = `NUM_SOURCES,
  parameter int SLOW_COUNT = `SLOW_START_CYC,
  parameter int FAST_COUNT = `FAST_START_CYC
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         power_ok,
  input  wire logic         reset_pin_n,
  input  wire logic         wd_enable,
  input  wire logic         wd_timeout,
  input  wire logic         watchdog_oscillator,
  input  wire logic         fast_start_fuse,
  input  wire logic [N-1:0] irq_event,
  input  wire logic [N-1:0] irq_enable,
  input  wire logic [N-1:0] irq_sw_clear,
  input  wire logic         global_set,
  input  wire logic         global_clear,
  input  wire logic         return_from_interrupt_instr,
  input  wire logic         irq_ack,
  output logic              core_reset,
  output logic              io_reset,
  output logic              irq_valid,
  output logic [15:0]       vector_addr,
  output logic              global_en,
  output logic [N-1:0]      irq_pending,
  output logic [1:0]        reset_cause
);

  rst_state_t   state_r;
  logic         por_s;
  logic         pin_s;
  logic         osc_s;
  logic         osc_prev_r;
  logic         osc_tick;
  logic [2:0]   pin_low_cnt_r;
  logic         pin_reset_r;
  logic         wd_pulse_r;
  logic         any_reset;
  logic [14:0]  delay_cnt_r;
  logic [14:0]  delay_target;
  logic [N-1:0] grant;
  vec_req_t     req;
  logic         accept;
  logic [N-1:0] served_r;

  // ==========================================================
  // Input synchronisers
  sync_two_ff #(.RESET_VAL(1'b0)) u_sync_por (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (power_ok),
    .sync_out (por_s)
  );

  // Pin resets to its idle high level, so release shows no false pin cause
  sync_two_ff #(.RESET_VAL(1'b1)) u_sync_pin (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (reset_pin_n),
    .sync_out (pin_s)
  );

  sync_two_ff #(.RESET_VAL(1'b0)) u_sync_osc (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (watchdog_oscillator),
    .sync_out (osc_s)
  );

  // ==========================================================
  // Oscillator edge enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= osc_s;
  end

  // R13: rising oscillator edge tick
  assign osc_tick = osc_s & ~osc_prev_r;

  // ==========================================================
  // Reset pin low filter
  // R9: pin low longer than filter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_low_cnt_r <= 3'h0;
      pin_reset_r   <= 1'b1;
    end
    else if (pin_s)
    begin
      pin_low_cnt_r <= 3'h0;
      pin_reset_r   <= 1'b0;
    end
    else if (pin_low_cnt_r >= 3'(`RST_FILTER_CYC - 1))
      pin_reset_r   <= 1'b1;
    else
      pin_low_cnt_r <= pin_low_cnt_r + 3'h1;
  end

  // ==========================================================
  // Watchdog reset pulse, held until the next oscillator tick
  // R10: only when enabled and expired
  // R15: pulse lasts until the next oscillator tick
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wd_pulse_r <= 1'b0;
    else if (wd_enable && wd_timeout && state_r == ST_RUN)
      wd_pulse_r <= 1'b1;
    else if (osc_tick)
      wd_pulse_r <= 1'b0;
  end

  // R8: combine the three causes
  // R14: pin held low keeps reset
  assign any_reset = ~por_s | pin_reset_r | wd_pulse_r;

  // R12: fuse selects terminal count
  assign delay_target = fast_start_fuse ? 15'(FAST_COUNT - 1) : 15'(SLOW_COUNT - 1);

  // ==========================================================
  // Start-up sequencer
  // R20: counter cleared by any reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r     <= ST_HOLD;
      delay_cnt_r <= 15'h0000;
    end
    else if (any_reset)
    begin
      state_r     <= ST_HOLD;
      delay_cnt_r <= 15'h0000;
    end
    else
    begin
      case (state_r)
        ST_HOLD:
          state_r <= ST_DELAY;
        ST_DELAY:
          if (osc_tick)
          begin
            if (delay_cnt_r >= delay_target)
              state_r <= ST_RUN;
            else
              delay_cnt_r <= delay_cnt_r + 15'h0001;
          end
        ST_RUN:
          state_r <= ST_RUN;
        default:
          state_r <= ST_HOLD;
      endcase
    end
  end

  // ==========================================================
  // Reset outputs and cause record
  // R11: registers forced during reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_reset <= 1'b1;
      io_reset   <= 1'b1;
    end
    else
    begin
      core_reset <= (state_r != ST_RUN) | any_reset;
      io_reset   <= any_reset;
    end
  end

  // Last reset cause: 1 power, 2 pin, 3 watchdog
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reset_cause <= 2'h1;
    else if (~por_s)
      reset_cause <= 2'h1;
    else if (pin_reset_r)
      reset_cause <= 2'h2;
    else if (wd_pulse_r)
      reset_cause <= 2'h3;
  end

  // ==========================================================
  // Arbitration
  // R3: lowest vector first
  irq_arbiter #(.N(N)) u_arb (
    .pending   (irq_pending),
    .enable    (irq_enable),
    .global_en (global_en),
    .grant     (grant),
    .req       (req)
  );

  // R2: taken only when enabled
  assign accept = irq_ack & irq_valid & ~core_reset;

  // ==========================================================
  // Served source, latched with the presented vector
  // R17: clear the presented source
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      served_r <= '0;
    else if (core_reset || any_reset)
      served_r <= '0;
    else if (!accept)
      served_r <= grant;
  end

  // ==========================================================
  // Pending flags
  // R18: stay pending while disabled
  // R17: clear served flag on vectoring
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_pending <= '0;
    else if (io_reset)
      irq_pending <= '0;
    else
      irq_pending <= irq_event | (irq_pending & ~irq_sw_clear & ~(accept ? served_r : '0));
  end

  // ==========================================================
  // Global enable
  // R16: accept clears, return sets
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      global_en <= 1'b0;
    else if (io_reset)
      global_en <= 1'b0;
    else if (accept)
      global_en <= 1'b0;
    else if (return_from_interrupt_instr || global_set)
      global_en <= 1'b1;
    else if (global_clear)
      global_en <= 1'b0;
  end

  // ==========================================================
  // Vector to the core
  // R4: reset vectors to zero
  // R19: address is vector number minus one
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_valid   <= 1'b0;
      vector_addr <= 16'h0000;
    end
    else if (core_reset || any_reset)
    begin
      irq_valid   <= 1'b0;
      vector_addr <= {12'h000, `VEC_RESET};
    end
    else if (accept)
      irq_valid   <= 1'b0;
    else
    begin
      // R1: one vector per source
      // R5: external irqs at 0x001, 0x002
      // R6: timers at 0x003 to 0x007
      // R7: others at 0x008 to 0x00C
      irq_valid   <= req.valid;
      vector_addr <= {12'h000, req.addr};
    end
  end

endmodule

// *** bench/vector_checker_assertions.sv ***
// Port checks for the vectoring unit
`timescale 1ns/1ps
module vector_checker #(
  parameter int N = 12
) (
  input wire logic         clk,
  input wire logic         reset_n,
  input wire logic [N-1:0] irq_event,
  input wire logic [N-1:0] irq_enable,
  input wire logic         global_set,
  input wire logic         global_clear,
  input wire logic         return_from_interrupt_instr,
  input wire logic         irq_ack,
  input wire logic         core_reset,
  input wire logic         io_reset,
  input wire logic         irq_valid,
  input wire logic [15:0]  vector_addr,
  input wire logic         global_en,
  input wire logic [N-1:0] irq_pending
);
  logic [3:0]   idx;
  logic         take;
  logic [N-1:0] sel;
  // Served index, accept strobe, its one-hot
  assign idx  = vector_addr[3:0] - 4'h1;
  assign take = irq_valid && irq_ack && !core_reset;
  assign sel  = N'(1) << idx;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Reset and vectoring
  a_io_holds_core: assert property (io_reset |-> core_reset)
    else $error("io reset without core hold");
  a_reset_vec_zero: assert property (io_reset |-> vector_addr == 16'h0000 && !irq_valid)
    else $error("vector not zero in reset");
  a_reset_clears_flags: assert property (io_reset [*2] |-> irq_pending == '0)
    else $error("flags kept in reset");
  a_accept_drops_ge: assert property (take && !global_set |=> !global_en)
    else $error("global enable kept after accept");
  a_accept_drops_flag: assert property (take && !irq_event[idx] |=> !irq_pending[$past(idx)])
    else $error("served flag kept");
  a_return_sets_ge: assert property (return_from_interrupt_instr && !take && !global_clear
    && !io_reset |=> global_en)
    else $error("return did not set global enable");
  a_event_pends: assert property (|irq_event && !io_reset |=>
    (irq_pending & $past(irq_event)) == $past(irq_event) || io_reset)
    else $error("event not held pending");
  a_vec_in_range: assert property (irq_valid |-> vector_addr inside {[16'h0001:16'h000C]})
    else $error("vector out of range");
  a_lowest_wins: assert property ($rose(irq_valid) |->
    ($past(irq_pending & irq_enable) & (sel | (sel - N'(1)))) == sel)
    else $error("not the lowest vector");
  cover property (take);
  cover property ($rose(io_reset));
  cover property ($fell(core_reset));
endmodule

bind reset_and_interrupt_vectoring vector_checker #(.N(N)) chk_i (.clk, .reset_n, .irq_event,
  .irq_enable, .global_set, .global_clear, .return_from_interrupt_instr, .irq_ack, .core_reset,
  .io_reset, .irq_valid, .vector_addr, .global_en, .irq_pending);

// *** bench/core_model.sv ***
// Core model answering vector requests
`timescale 1ns/1ps
module core_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       irq_valid,
  input  wire logic       core_reset,
  input  wire logic [2:0] ack_wait,
  output logic            irq_ack
);
  logic [2:0] wait_r;
  // Acknowledge after ack_wait standing cycles
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_r  <= 3'h0;
      irq_ack <= 1'b0;
    end
    else if (irq_valid && !core_reset && !irq_ack)
    begin
      irq_ack <= (wait_r >= ack_wait);
      wait_r  <= wait_r + 3'h1;
    end
    else
    begin
      irq_ack <= 1'b0;
      wait_r  <= 3'h0;
    end
  end
endmodule

// *** bench/reset_and_interrupt_vectoring_bench.sv ***
// Self-checking bench for the vectoring unit
`timescale 1ns/1ps
module reset_and_interrupt_vectoring_bench;
  localparam int N = 12;
  localparam int OSC_CYC = 7;
  localparam int SLOW_TICKS = 8;
  localparam int FAST_TICKS = 4;
  logic clk = 0, reset_n = 0, pwr = 0, pin_n = 1, wd_en = 0, wd_to = 0, osc = 0;
  logic fuse = 0, g_set = 0, g_clr = 0, ret = 0, got = 0;
  logic [N-1:0] ev = '0, en = '0, swc = '0, pend;
  logic [2:0] ack_wait = 3'h0;
  logic core_rst, io_rst, valid, ge, ack;
  logic [15:0] vaddr, got_addr;
  logic [1:0] cause;
  int error_cnt = 0, check_count = 0, cycles = 0;
  integer seed = 32'h457E6B8A;

  always #50 clk = ~clk;
  // Oscillator edges fall between clock edges, so sampling is race free
  initial
  begin
    #25;
    forever #350 osc = ~osc;
  end

  reset_and_interrupt_vectoring #(.SLOW_COUNT(SLOW_TICKS), .FAST_COUNT(FAST_TICKS)) DUT (
    .clk(clk),
    .reset_n(reset_n), .power_ok(pwr), .reset_pin_n(pin_n), .wd_enable(wd_en),
    .wd_timeout(wd_to), .watchdog_oscillator(osc), .fast_start_fuse(fuse), .irq_event(ev),
    .irq_enable(en), .irq_sw_clear(swc), .global_set(g_set), .global_clear(g_clr),
    .return_from_interrupt_instr(ret), .irq_ack(ack), .core_reset(core_rst),
    .io_reset(io_rst), .irq_valid(valid), .vector_addr(vaddr), .global_en(ge),
    .irq_pending(pend), .reset_cause(cause));
  core_model core_i (.clk(clk), .reset_n(reset_n), .irq_valid(valid),
    .core_reset(core_rst), .ack_wait(ack_wait), .irq_ack(ack));

  // Record accepted vectors, cut hangs
  always @(posedge clk)
  begin
    if (valid && ack && !core_rst)
    begin
      got      <= 1'b1;
      got_addr <= vaddr;
    end
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      error_cnt = error_cnt + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] act);
    check_count++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, act);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // Release window for a tick count: ticks apart, plus phase and sync slack
  function automatic logic delay_fits(input int cyc, input int ticks);
    delay_fits = (cyc >= (ticks - 1) * OSC_CYC + 1) && (cyc <= ticks * OSC_CYC + 8);
  endfunction

  // Wait for the core, judge the delay length
  task automatic wait_run(input logic slow);
    int i;
    for (i = 0; i < 400 && core_rst !== 1'b0; i++)
      tick(1);
    chk("start_delay", 16'h1, {15'h0, delay_fits(i, slow ? SLOW_TICKS : FAST_TICKS)});
  endtask

  function automatic logic [15:0] first_vec(input logic [N-1:0] m);
    first_vec = 16'h0000;
    for (int b = N - 1; b >= 0; b--)
      if (m[b])
        first_vec = 16'(b + 1);
  endfunction

  initial
  begin
    int k, i;
    logic [N-1:0] m, s;
    tick(20);
    chk("reset_vec", 16'h0000, vaddr);
    chk("reset_cause", 16'h1, {14'h0, cause});
    reset_n = 1;
    pwr = 1;
    wait_run(1'b1);
    // Random bursts with corner masks
    for (k = 0; k < 10; k++)
    begin
      m = (k == 0) ? '1 : (k == 1) ? 12'h800 : N'($random(seed));
      en = (k < 3) ? '1 : N'($random(seed));
      ack_wait = 3'(k);
      ev = m;
      tick(1);
      ev = '0;
      tick(3);
      chk("held", 16'h0, {15'h0, valid});
      chk("pending", 16'(m), 16'(pend));
      s = m & en;
      while (s != '0)
      begin
        got = 0;
        if (k == 0)
          g_set = 1;
        else
          ret = 1;
        tick(1);
        g_set = 0;
        ret = 0;
        chk("ge_set", 16'h1, {15'h0, ge});
        for (i = 0; i < 20 && !got; i++)
          tick(1);
        chk("vector", first_vec(s), got_addr);
        chk("ge_accept", 16'h0, {15'h0, ge});
        s = s & ~(N'(1) << (first_vec(s) - 16'h1));
      end
      tick(2);
      chk("left", 16'(m & ~en), 16'(pend));
      swc = m & ~en;
      tick(1);
      swc = '0;
      tick(1);
      chk("sw_clear", 16'h0, 16'(pend));
    end
    // Global clear blocks every source
    en = '1;
    g_set = 1;
    tick(1);
    g_set = 0;
    g_clr = 1;
    tick(1);
    g_clr = 0;
    ev = '1;
    tick(1);
    ev = '0;
    tick(3);
    chk("ge_clear", 16'h0, {15'h0, ge});
    chk("clr_held", 16'h0, {15'h0, valid});
    pin_n = 0;
    tick(5);
    chk("pin_io", 16'h1, {15'h0, io_rst});
    chk("pin_cause", 16'h2, {14'h0, cause});
    pin_n = 1;
    fuse = 1;
    wait_run(1'b0);
    wd_to = 1;
    tick(1);
    wd_to = 0;
    tick(4);
    chk("wd_off", 16'h0, {15'h0, io_rst});
    wd_en = 1;
    wd_to = 1;
    tick(1);
    wd_to = 0;
    wd_en = 0;
    tick(1);
    chk("wd_cause", 16'h3, {14'h0, cause});
    wait_run(1'b0);
    pwr = 0;
    tick(4);
    chk("pwr_cause", 16'h1, {14'h0, cause});
    pin_n = 0;
    pwr = 1;
    fuse = 0;
    tick(100);
    chk("pin_extends", 16'h1, {15'h0, core_rst});
    pin_n = 1;
    wait_run(1'b1);
    print_verdict();
  end
endmodule
